// *** src/light_curtain_safety_output_logic.sv ***
// Behaviour
// - Any completely blocked beam switches the safety outputs off.
// - Synchronisation comes from the optical path only, no electrical link.
// - Field width is measured and adopted at every power-up.
// - Three selectable width ranges per resolution; width may vary inside.
// - Exactly one beam coding: uncoded, code 1 or code 2.
// - Reduced resolution tolerates up to two adjacent blocked beams.
// - Indicators one to four show alignment quality after power-up.
// - Indicators five, six show top beam sync; seven, eight bottom.
// - A switchable control turns the laser alignment aid on and off.
// - Restart interlock keeps outputs off after trip until reset button.
// - Feedback monitoring checks contactors drop out after outputs switch off.
// - Diagnostic output carries one configured status signal.
// - Cascade of at most three units: one host, two guests.
// - Presence mode: guests sleep until host trips, then wake; outputs off.
// - Presence mode: outputs stay off while any field is interrupted.
// - All fields clear 0.5 s: outputs on again, guests sleep.
//
// Local design decisions: register access over APB and the placing of the registers.
`include "light_curtain_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module light_curtain_safety_output_logic #(
  parameter logic [`TIMER_W-1:0] CLEAR_CYCLES =
    `TIMER_W'(`CLEAR_TIME_MS * (`CLK_HZ / 1000)),
  parameter logic [`TIMER_W-1:0] FEEDBACK_CYCLES =
    `TIMER_W'(`FEEDBACK_TIME_MS * (`CLK_HZ / 1000))
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEnable,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Optical front end, same clock
  input wire light_curtain_pkg::beams_t beamBlocked,
  input wire logic opticalSync,
  input wire logic [1:0] rxCode,
  input wire logic syncTop,
  input wire logic syncBottom,
  input wire logic [2:0] alignLevel,
  input wire logic weakSignal,
  input wire light_curtain_pkg::width_t liveWidth,
  input wire logic widthValid,
  input wire logic mutingActive,
  input wire logic overrideRequired,
  input wire logic validObject,
  // Pins
  input wire logic resetButton,
  input wire logic contactorFeedbackMonitor,
  input wire logic [1:0] guestBlocked,
  output logic [1:0] safetySwitchOutputs,
  output logic [1:0] guestWake,
  output logic laserOn,
  output logic diagOut,
  output logic [7:0] diagLed
);
  import light_curtain_pkg::*;

  state_t state, next_state;
  logic [14:0] ctrl;
  width_t calibWidth, widthMin, widthMax;
  beams_t lowest, pairMask;
  logic [`TIMER_W-1:0] clearTimer, fbTimer;
  logic [3:0] syncStage1, syncStage2, alignBar;
  logic [1:0] guestSync, guestActive, guestMask, guestCount;
  logic calibrated, feedbackFault, tripped, buttonPrev, buttonPress, contactorDropped;
  logic tolerated, fieldViolated, guestInterrupted, anyInterrupted, syncOk, rangeFault;
  logic trip, clearDone, contactorOk, canRestart, rangeBad, apbWrite, apbSetup, addrOk;

  assign guestCount = ctrl[`CTRL_GUESTS_LSB +: 2];

  // Two-flop synchronisers for the pins; stage one feeds stage two only
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncStage1 <= 4'h0;
      syncStage2 <= 4'h0;
      buttonPrev <= 1'b0;
    end else if (clkEnable) begin
      syncStage1 <= {guestBlocked, contactorFeedbackMonitor, resetButton};
      syncStage2 <= syncStage1;
      buttonPrev <= syncStage2[0];
    end
  end

  assign buttonPress = syncStage2[0] & ~buttonPrev;
  assign contactorDropped = syncStage2[1];
  assign guestSync = syncStage2[3:2];

  // Blocked-beam evaluation; a run of one or two adjacent beams is tolerable
  assign lowest = beamBlocked & (~beamBlocked + `BEAM_COUNT'(1));
  assign pairMask = lowest | (lowest << 1);
  assign tolerated = ctrl[`CTRL_REDUCED] && (beamBlocked != '0) &&
                     (beamBlocked == lowest || beamBlocked == pairMask);
  assign fieldViolated = (beamBlocked != '0) && !tolerated;

  // Guests count only if fitted and, in presence mode, awake
  generate
    for (genvar g = 0; g < `GUEST_COUNT; g++) begin : gen_guest
      assign guestMask[g] = (2'(g) < guestCount);
      assign guestActive[g] = guestMask[g] &&
                              (!ctrl[`CTRL_PRESENCE] || guestWake[g]);
    end
  endgenerate

  assign guestInterrupted = |(guestSync & guestActive);
  assign anyInterrupted = fieldViolated || guestInterrupted;

  // Optical sync counts only with the configured coding
  assign syncOk = opticalSync && (ctrl[`CTRL_CODE_LSB +: 2] != 2'h3) &&
                  (rxCode == ctrl[`CTRL_CODE_LSB +: 2]);

  // Allowed width window per resolution and range
  always_comb begin
    widthMin = `W30_MIN;
    widthMax = `W30_LARGE_MAX;
    rangeBad = 1'b0;
    case ({ctrl[`CTRL_RES30], ctrl[`CTRL_RANGE_LSB +: 2]})
      {1'b0, `RANGE_SMALL}: {widthMin, widthMax} = {`W14_SMALL_MIN, `W14_SMALL_MAX};
      {1'b0, `RANGE_MEDIUM}: {widthMin, widthMax} = {`W14_MEDIUM_MIN, `W14_MEDIUM_MAX};
      {1'b0, `RANGE_LARGE}: {widthMin, widthMax} = {`W14_LARGE_MIN, `W14_LARGE_MAX};
      {1'b1, `RANGE_SMALL}: widthMax = `W30_SMALL_MAX;
      {1'b1, `RANGE_MEDIUM}: widthMax = `W30_MEDIUM_MAX;
      {1'b1, `RANGE_LARGE}: widthMax = `W30_LARGE_MAX;
      default: rangeBad = 1'b1;
    endcase
  end

  // Width may drift inside the window; leaving it trips the field
  assign rangeFault = calibrated && (rangeBad || liveWidth < widthMin ||
                      liveWidth > widthMax);
  assign trip = anyInterrupted || !syncOk || rangeFault;
  assign clearDone = (clearTimer == CLEAR_CYCLES - `TIMER_W'(1));
  assign contactorOk = !ctrl[`CTRL_FEEDBACK] || contactorDropped;
  // A fresh interruption blocks restart even when the clear time has just run out
  assign canRestart = !trip && (!ctrl[`CTRL_PRESENCE] || clearDone) && contactorOk;

  // Width captured once per power-up, after first valid sync
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      calibrated <= 1'b0;
      calibWidth <= '0;
    end else if (clkEnable && !calibrated && syncOk && widthValid) begin
      calibrated <= 1'b1;
      calibWidth <= liveWidth;
    end
  end

  // Clear-time counter; restarts on any interruption
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clearTimer <= '0;
    end else if (clkEnable) begin
      if (trip) begin
        clearTimer <= '0;
      end else if (!clearDone) begin
        clearTimer <= clearTimer + `TIMER_W'(1);
      end
    end
  end

  // Contactors must drop within the feedback time once outputs are off
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fbTimer <= '0;
    end else if (clkEnable) begin
      if (!ctrl[`CTRL_FEEDBACK] || safetySwitchOutputs[0] || contactorDropped) begin
        fbTimer <= '0;
      end else if (fbTimer != FEEDBACK_CYCLES - `TIMER_W'(1)) begin
        fbTimer <= fbTimer + `TIMER_W'(1);
      end
    end
  end

  // Sticky feedback fault; a new detection beats a software clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      feedbackFault <= 1'b0;
    end else if (clkEnable) begin
      if (fbTimer == FEEDBACK_CYCLES - `TIMER_W'(1)) begin
        feedbackFault <= 1'b1;
      end else if (apbWrite && paddr == `ADDR_STATUS && pwdata[`STAT_FB_FAULT]) begin
        feedbackFault <= 1'b0;
      end
    end
  end

  // Output state machine
  always_comb begin
    next_state = state;
    case (state)
      ST_CALIB: if (calibrated && syncOk) next_state = ST_OFF;
      ST_ON: if (trip) next_state = ST_OFF;
      ST_OFF: begin
        if (canRestart) begin
          next_state = (ctrl[`CTRL_RESTART] && tripped) ? ST_WAIT_RESET : ST_ON;
        end
      end
      ST_WAIT_RESET: begin
        if (trip) begin
          next_state = ST_OFF;
        end else if (buttonPress && contactorOk) begin
          next_state = ST_ON;
        end
      end
      ST_FAULT: if (!feedbackFault) next_state = ST_OFF;
      default: next_state = ST_CALIB;
    endcase
    if (feedbackFault && state != ST_CALIB) begin
      next_state = ST_FAULT;
    end
  end

  // State, trip memory and safety outputs move together
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_CALIB;
      tripped <= 1'b0;
      safetySwitchOutputs <= 2'h0;
    end else if (clkEnable) begin
      state <= next_state;
      safetySwitchOutputs <= {2{next_state == ST_ON}};
      if (state == ST_ON && next_state != ST_ON) begin
        tripped <= 1'b1;
      end else if (next_state == ST_ON) begin
        tripped <= 1'b0;
      end
    end
  end

  // Guests wake on a host trip and sleep again after the clear time
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      guestWake <= 2'h0;
    end else if (clkEnable) begin
      if (!ctrl[`CTRL_PRESENCE]) begin
        guestWake <= guestMask;
      end else if (fieldViolated) begin
        guestWake <= guestMask;
      end else if (clearDone) begin
        guestWake <= 2'h0;
      end
    end
  end

  // Alignment bar of four; one register holds all lamps, so one process drives it
  generate
    for (genvar i = 0; i < 4; i++) begin : gen_align
      assign alignBar[i] = (alignLevel > 3'(i));
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      diagLed <= 8'h00;
    end else if (clkEnable) begin
      diagLed <= {{2{syncBottom}}, {2{syncTop}}, alignBar};
    end
  end

  // Diagnostic output mux; unknown selections stay dark
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      diagOut <= 1'b0;
    end else if (clkEnable) begin
      case (ctrl[`CTRL_DIAG_LSB +: 3])
        `DIAG_RESET_REQ: diagOut <= (state == ST_WAIT_RESET);
        `DIAG_WEAK: diagOut <= weakSignal;
        `DIAG_IGNORED: diagOut <= tolerated;
        `DIAG_MUTING: diagOut <= mutingActive;
        `DIAG_OVERRIDE: diagOut <= overrideRequired;
        `DIAG_VALID_OBJ: diagOut <= validObject;
        default: diagOut <= 1'b0;
      endcase
    end
  end

  // APB: zero wait states, read data latched in the setup cycle
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite && addrOk;
  assign addrOk = (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS) ||
                  (paddr == `ADDR_WIDTH);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addrOk;

  // Configuration; laser aid follows its bit directly
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl <= `CTRL_RESET;
    end else if (clkEnable && apbWrite && paddr == `ADDR_CTRL) begin
      ctrl <= pwdata[14:0];
    end
  end

  assign laserOn = ctrl[`CTRL_LASER];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0;
    end else if (clkEnable && apbSetup) begin
      case (paddr)
        `ADDR_CTRL: prdata <= {17'h0, ctrl};
        `ADDR_STATUS: prdata <= {24'h0, guestWake, rangeFault, calibrated, syncOk,
                                 feedbackFault, state == ST_WAIT_RESET,
                                 safetySwitchOutputs[0]};
        `ADDR_WIDTH: prdata <= {liveWidth, calibWidth};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_on_trip;
    clkEnable && state == ST_ON && trip;
  endsequence

  sequence s_host_hit;
    clkEnable && ctrl[`CTRL_PRESENCE] && fieldViolated && !feedbackFault;
  endsequence

  trip_drops_out_a: assert property (s_on_trip |=> safetySwitchOutputs == 2'h0)
    else $error("outputs stayed on after a trip");
  calib_holds_off_a: assert property (!calibrated |-> safetySwitchOutputs == 2'h0)
    else $error("outputs on before calibration");
  pair_tolerated_a: assert property (ctrl[`CTRL_REDUCED] && beamBlocked == 32'h0000_0006
    |-> !fieldViolated)
    else $error("two adjacent beams tripped under reduced resolution");
  gap_trips_a: assert property (beamBlocked == 32'h0000_0005 |-> fieldViolated)
    else $error("non-adjacent beams tolerated");
  interlock_holds_a: assert property (clkEnable && state == ST_WAIT_RESET && !buttonPress
    && !feedbackFault |=> safetySwitchOutputs == 2'h0)
    else $error("outputs on without reset press");
  feedback_fault_a: assert property (clkEnable && ctrl[`CTRL_FEEDBACK] &&
    fbTimer == FEEDBACK_CYCLES - `TIMER_W'(1) |=> feedbackFault ##1 state == ST_FAULT
    || !clkEnable)
    else $error("contactor fault not raised");
  diag_reset_req_a: assert property (clkEnable && ctrl[`CTRL_DIAG_LSB +: 3] ==
    `DIAG_RESET_REQ |=> diagOut == $past(state == ST_WAIT_RESET))
    else $error("diagnostic output wrong for reset required");
  guests_wake_a: assert property (s_host_hit |=> guestWake == $past(guestMask))
    else $error("guests not woken by host trip");
  hold_while_hit_a: assert property (clkEnable && ctrl[`CTRL_PRESENCE] && anyInterrupted
    |=> safetySwitchOutputs == 2'h0)
    else $error("outputs on while a field is interrupted");
  clear_time_a: assert property (clkEnable && ctrl[`CTRL_PRESENCE] && state == ST_OFF
    && !clearDone |=> safetySwitchOutputs == 2'h0)
    else $error("outputs on before clear time");
  top_led_a: assert property (clkEnable |=> diagLed[5:4] == {2{$past(syncTop)}})
    else $error("top sync indicator wrong");

endmodule // light_curtain_safety_output_logic

`default_nettype wire

// *** src/light_curtain_defs.svh ***
`ifndef LIGHT_CURTAIN_DEFS_SVH
`define LIGHT_CURTAIN_DEFS_SVH

// Geometry
`define BEAM_COUNT 32
`define GUEST_COUNT 2
`define WIDTH_W 16
`define TIMER_W 26

// APB byte offsets
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_WIDTH 12'h008

// Control register fields
`define CTRL_RESTART 0
`define CTRL_FEEDBACK 1
`define CTRL_REDUCED 2
`define CTRL_PRESENCE 3
`define CTRL_LASER 4
`define CTRL_RES30 5
`define CTRL_CODE_LSB 6
`define CTRL_RANGE_LSB 8
`define CTRL_DIAG_LSB 10
`define CTRL_GUESTS_LSB 13
`define CTRL_RESET 15'h0000

// Status register fields
`define STAT_SAFE_ON 0
`define STAT_WAIT_RESET 1
`define STAT_FB_FAULT 2
`define STAT_SYNC_OK 3
`define STAT_CALIBRATED 4
`define STAT_RANGE_FAULT 5
`define STAT_WAKE_LSB 6

// Beam codings
`define CODE_NONE 2'h0
`define CODE_ONE 2'h1
`define CODE_TWO 2'h2

// Field-width ranges
`define RANGE_SMALL 2'h0
`define RANGE_MEDIUM 2'h1
`define RANGE_LARGE 2'h2

// Diagnostic output selections
`define DIAG_RESET_REQ 3'h0
`define DIAG_WEAK 3'h1
`define DIAG_IGNORED 3'h2
`define DIAG_MUTING 3'h3
`define DIAG_OVERRIDE 3'h4
`define DIAG_VALID_OBJ 3'h5

// Field-width limits in mm
`define W14_SMALL_MIN 16'h0096
`define W14_SMALL_MAX 16'h1388
`define W14_MEDIUM_MIN 16'h03e8
`define W14_MEDIUM_MAX 16'h2710
`define W14_LARGE_MIN 16'h07d0
`define W14_LARGE_MAX 16'h4e20
`define W30_MIN 16'h0000
`define W30_SMALL_MAX 16'h1d4c
`define W30_MEDIUM_MAX 16'h3a98
`define W30_LARGE_MAX 16'h7530

// Timing
`define CLK_HZ 100000000
`define CLEAR_TIME_MS 500
`define FEEDBACK_TIME_MS 300

`endif

// *** src/light_curtain_pkg.sv ***
package light_curtain_pkg;
  typedef enum logic [2:0] {ST_CALIB, ST_OFF, ST_WAIT_RESET, ST_ON, ST_FAULT} state_t;
  typedef logic [31:0] beams_t;
  typedef logic [15:0] width_t;
endpackage

// *** verification/contactor_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module contactor_model (
  input wire logic ref_clk,
  input wire logic [1:0] safetySwitchOutputs,
  input wire logic slow,
  input wire logic weld,
  output logic contactorFeedbackMonitor
);
  logic [5:0] coil = '0;

  // Coil pulls in only while both channels are on; mechanics lag it
  always_ff @(posedge ref_clk) begin
    coil <= {coil[4:0], &safetySwitchOutputs};
  end

  // Guided aux contact closes once dropped; a welded contactor never drops
  assign contactorFeedbackMonitor = ~(weld | (slow ? coil[4] : coil[1]));
endmodule // contactor_model

`default_nettype wire

// *** verification/tb_light_curtain_safety_output_logic.sv ***
`timescale 1ns/1ps
`include "light_curtain_defs.svh"
`default_nettype none

module tb_light_curtain_safety_output_logic;
  import light_curtain_pkg::*;
  localparam int CLR = 20;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr;
  beams_t beamBlocked = '0;
  width_t liveWidth = '0;
  logic [1:0] rxCode = '0;
  logic [2:0] alignLevel = '0;
  logic opticalSync = 1'b0;
  logic syncTop = 1'b0;
  logic syncBottom = 1'b0;
  logic weakSignal = 1'b0;
  logic widthValid = 1'b0;
  logic mutingActive = 1'b0;
  logic overrideRequired = 1'b0;
  logic validObject = 1'b0;
  logic resetButton = 1'b0;
  logic [1:0] guestBlocked = '0;
  logic slow = 1'b0;
  logic weld = 1'b0;
  logic fb, laserOn, diagOut;
  logic [1:0] safeOut, guestWake;
  logic [7:0] diagLed;
  logic [31:0] rv;
  logic re;
  int failures = 0;
  int n_checks = 0;

  // Free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  light_curtain_safety_output_logic #(
    .CLEAR_CYCLES(`TIMER_W'(CLR)), .FEEDBACK_CYCLES(`TIMER_W'(10))
  ) i_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clkEnable(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .beamBlocked(beamBlocked), .opticalSync(opticalSync), .rxCode(rxCode),
    .syncTop(syncTop), .syncBottom(syncBottom), .alignLevel(alignLevel),
    .weakSignal(weakSignal), .liveWidth(liveWidth), .widthValid(widthValid),
    .mutingActive(mutingActive), .overrideRequired(overrideRequired),
    .validObject(validObject), .resetButton(resetButton),
    .contactorFeedbackMonitor(fb), .guestBlocked(guestBlocked),
    .safetySwitchOutputs(safeOut), .guestWake(guestWake), .laserOn(laserOn),
    .diagOut(diagOut), .diagLed(diagLed)
  );

  contactor_model i_contactor (
    .ref_clk(ref_clk), .safetySwitchOutputs(safeOut), .slow(slow), .weld(weld),
    .contactorFeedbackMonitor(fb)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Settle one time unit past the edge so design updates have landed
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // APB transfer; waits on pready, the watchdog bounds a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, '0);
    chk(nm, e, rv);
  endtask

  task automatic waitOut(input logic [1:0] e, input int lim);
    int i;
    i = 0;
    while (safeOut !== e && i < lim) begin
      tk(1);
      i++;
    end
    chk("outputs", 32'(e), 32'(safeOut));
  endtask

  task automatic blip(input logic [31:0] b);
    @(posedge ref_clk);
    beamBlocked <= b;
    tk(1);
    @(posedge ref_clk);
    beamBlocked <= '0;
    #1;
  endtask

  task automatic t_calib();
    tk(6);
    chk("before sync", 0, 32'(safeOut));
    @(posedge ref_clk);
    opticalSync <= 1'b1;
    liveWidth <= 16'h0bb8;
    widthValid <= 1'b1;
    waitOut(2'b11, 10);
    rdc(`ADDR_WIDTH, 32'h0bb8_0bb8, "width");
    @(posedge ref_clk);
    liveWidth <= 16'h0fa0;
    tk(2);
    rdc(`ADDR_WIDTH, 32'h0fa0_0bb8, "width live");
    chk("width moved", 3, 32'(safeOut));
    rdc(`ADDR_CTRL, 0, "ctrl reset");
    rdc(`ADDR_STATUS, 32'h19, "status");
    apb(1'b0, 12'h00c, '0);
    chk("unmapped err", 1, 32'(re));
    chk("unmapped data", 0, rv);
    apb(1'b1, `ADDR_WIDTH, '0);
    rdc(`ADDR_WIDTH, 32'h0fa0_0bb8, "width ro");
    apb(1'b1, `ADDR_CTRL, 32'h10);
    chk("laser", 1, 32'(laserOn));
    apb(1'b1, `ADDR_CTRL, 0);
    chk("laser off", 0, 32'(laserOn));
    $display("done calib");
  endtask

  task automatic t_trip();
    blip(32'h8000_0000);
    waitOut(2'b11, 5);
    @(posedge ref_clk);
    beamBlocked <= 32'h8000_0000;
    tk(1);
    chk("trip", 0, 32'(safeOut));
    @(posedge ref_clk);
    beamBlocked <= '0;
    opticalSync <= 1'b0;
    tk(3);
    chk("sync lost", 0, 32'(safeOut));
    @(posedge ref_clk);
    opticalSync <= 1'b1;
    waitOut(2'b11, 5);
    $display("done trip");
  endtask

  task automatic t_reduced();
    logic [31:0] pat [3] = '{32'h1, 32'h380, 32'h5};
    apb(1'b1, `ADDR_CTRL, 32'h804);
    @(posedge ref_clk);
    beamBlocked <= 32'h6;
    tk(2);
    chk("two adjacent", 3, 32'(safeOut));
    chk("ignored", 1, 32'(diagOut));
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      beamBlocked <= pat[i];
      tk(1);
      chk("reduced", (i == 0) ? 3 : 0, 32'(safeOut));
      @(posedge ref_clk);
      beamBlocked <= '0;
      waitOut(2'b11, 5);
    end
    $display("done reduced");
  endtask

  task automatic t_diag();
    logic [2:0] sel [4] = '{`DIAG_WEAK, `DIAG_MUTING, `DIAG_OVERRIDE, `DIAG_VALID_OBJ};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `ADDR_CTRL, 32'(sel[i]) << 10);
      for (int v = 1; v >= 0; v--) begin
        @(posedge ref_clk);
        {weakSignal, mutingActive, overrideRequired, validObject} <= 4'(v) << (3 - i);
        tk(2);
        chk("diag", 32'(v), 32'(diagOut));
      end
    end
    apb(1'b1, `ADDR_CTRL, 32'h1800);
    @(posedge ref_clk);
    {weakSignal, mutingActive, overrideRequired, validObject} <= 4'hf;
    tk(2);
    chk("diag unused", 0, 32'(diagOut));
    @(posedge ref_clk);
    {weakSignal, mutingActive, overrideRequired, validObject} <= 4'h0;
    $display("done diag");
  endtask

  task automatic t_restart();
    apb(1'b1, `ADDR_CTRL, 32'h1);
    blip(32'h10);
    tk(8);
    chk("interlock", 0, 32'(safeOut));
    chk("reset req", 1, 32'(diagOut));
    rdc(`ADDR_STATUS, 32'h1a, "status wait");
    @(posedge ref_clk);
    resetButton <= 1'b1;
    waitOut(2'b11, 8);
    @(posedge ref_clk);
    resetButton <= 1'b0;
    $display("done restart");
  endtask

  task automatic t_code();
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, `ADDR_CTRL, 32'(c) << 6);
      @(posedge ref_clk);
      rxCode <= 2'(c);
      waitOut(2'b11, 6);
      @(posedge ref_clk);
      rxCode <= 2'(c + 1);
      tk(1);
      chk("wrong code", 0, 32'(safeOut));
    end
    @(posedge ref_clk);
    rxCode <= '0;
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `ADDR_CTRL, 32'(r) << 8);
      waitOut((r < 3) ? 2'b11 : 2'b00, 4);
      chk("range", (r < 3) ? 3 : 0, 32'(safeOut));
    end
    rdc(`ADDR_STATUS, 32'h38, "range fault");
    apb(1'b1, `ADDR_CTRL, 0);
    waitOut(2'b11, 5);
    for (int l = 0; l < 5; l++) begin
      @(posedge ref_clk);
      alignLevel <= 3'(l);
      syncTop <= l[0];
      syncBottom <= l[1];
      tk(2);
      chk("leds", 32'({l[1], l[1], l[0], l[0], 4'hf >> (4 - l)}), 32'(diagLed));
    end
    $display("done code");
  endtask

  task automatic t_feedback();
    apb(1'b1, `ADDR_CTRL, 32'h2);
    slow <= 1'b1;
    blip(32'h1);
    waitOut(2'b11, 20);
    rdc(`ADDR_STATUS, 32'h19, "slow drop");
    weld <= 1'b1;
    blip(32'h1);
    tk(20);
    rdc(`ADDR_STATUS, 32'h1c, "welded");
    weld <= 1'b0;
    tk(10);
    chk("fault held", 0, 32'(safeOut));
    apb(1'b1, `ADDR_STATUS, 32'h4);
    waitOut(2'b11, 10);
    $display("done feedback");
  endtask

  task automatic t_presence();
    apb(1'b1, `ADDR_CTRL, 32'h4008);
    tk(2);
    chk("asleep", 0, 32'(guestWake));
    @(posedge ref_clk);
    beamBlocked <= 32'h2;
    tk(1);
    chk("host trip", 0, 32'(safeOut));
    chk("awake", 3, 32'(guestWake));
    @(posedge ref_clk);
    beamBlocked <= '0;
    guestBlocked <= 2'b10;
    tk(2 * CLR);
    chk("guest held", 0, 32'(safeOut));
    @(posedge ref_clk);
    guestBlocked <= 2'b00;
    tk(CLR / 2);
    chk("clear time", 0, 32'(safeOut));
    waitOut(2'b11, CLR);
    chk("sleep again", 0, 32'(guestWake));
    apb(1'b1, `ADDR_CTRL, 32'h2008);
    blip(32'h2);
    chk("one guest", 1, 32'(guestWake));
    waitOut(2'b11, 2 * CLR);
    $display("done presence");
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence after a two-cycle reset
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_calib();
    t_trip();
    t_reduced();
    t_diag();
    t_restart();
    t_code();
    t_feedback();
    t_presence();
    stop_test();
  end

  // Whole run needs roughly four hundred cycles; twenty thousand is a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    stop_test();
  end
endmodule // tb_light_curtain_safety_output_logic

`default_nettype wire
